// ### exio_access.sv
`timescale 1ns/1ns
`default_nettype none
module exio_access (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          arst_n,
  // request from the program executor
  input  wire logic                          reqValid,
  input  wire logic                          reqWrite,
  input  wire logic                          reqOutput,
  input  wire logic                          reqGroup,
  input  wire logic [11:0]                   reqPoint,
  input  wire logic [4:0]                    reqLen,
  input  wire logic [exio_pkg::DATA_W-1:0]   reqData,
  // answer
  output logic                               respValid,
  output logic                               respError,
  output logic [exio_pkg::MAX_LEN-1:0]       respData,
  // field pins
  input  wire logic [exio_pkg::TOTAL-1:0]    inPins,
  output logic [exio_pkg::TOTAL-1:0]         outPins
);
  exio_dec_if dec ();

  logic [exio_pkg::TOTAL-1:0]   cmd_reg,       cmd_next;
  logic                         respValid_reg, respValid_next;
  logic                         respError_reg, respError_next;
  logic [exio_pkg::MAX_LEN-1:0] respData_reg,  respData_next;
  logic [4:0]                   effLen;
  logic                         accept;
  logic [7:0]                   pos;

  assign dec.pointBcd = reqPoint;
  assign dec.runLen   = effLen;

  exio_point_decode u_decode (
    .d (dec)
  );

  // ---------------------------------------------------------------
  // access logic
  // ---------------------------------------------------------------
  always_comb begin
    pos            = 8'h00;
    effLen         = reqGroup ? reqLen : exio_pkg::LEN_MIN;
    // writing an input point has no meaning and is refused
    accept         = dec.pointOk && dec.runOk && !(reqWrite && !reqOutput);
    cmd_next       = cmd_reg;
    respValid_next = reqValid;
    respError_next = reqValid && !accept;
    respData_next  = exio_pkg::RESP_RESET;
    if (reqValid && accept) begin
      for (int i = 0; i < exio_pkg::MAX_LEN; i++) begin
        pos = dec.flatIdx + 8'(i);
        if (5'(i) < effLen) begin
          if (reqWrite) begin
            // only run positions are touched, all else holds
            cmd_next[pos] = reqGroup ? reqData[i] : (reqData != '0);
          end else if (reqOutput) begin
            respData_next[i] = cmd_reg[pos];
          end else begin
            respData_next[i] = inPins[pos];
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_reg       <= '0;
      respValid_reg <= 1'b0;
      respError_reg <= 1'b0;
      respData_reg  <= exio_pkg::RESP_RESET;
    end else begin
      cmd_reg       <= cmd_next;
      respValid_reg <= respValid_next;
      respError_reg <= respError_next;
      respData_reg  <= respData_next;
    end
  end

  assign outPins   = cmd_reg;
  assign respValid = respValid_reg;
  assign respError = respError_reg;
  assign respData  = respData_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [7:0]                 idxSeen;
  logic [4:0]                 lenSeen;
  logic [exio_pkg::DATA_W-1:0] dataSeen;
  logic [exio_pkg::TOTAL-1:0] inSeen;
  logic [exio_pkg::TOTAL-1:0] cmdSeen;
  logic                       okNow;

  assign okNow = reqValid && accept;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      idxSeen  <= 8'h00;
      lenSeen  <= 5'h00;
      dataSeen <= '0;
      inSeen   <= '0;
      cmdSeen  <= '0;
    end else begin
      idxSeen  <= dec.flatIdx;
      lenSeen  <= effLen;
      dataSeen <= reqData;
      inSeen   <= inPins;
      cmdSeen  <= cmd_reg;
    end
  end

  property p_pointRange;
    @(posedge clock) disable iff (!arst_n)
      reqValid && !dec.pointOk |=> respValid && respError && (outPins == cmdSeen);
  endproperty
  a_pointRange: assert property (p_pointRange) else $error("bad point not refused");

  property p_lenRange;
    @(posedge clock) disable iff (!arst_n)
      reqValid && reqGroup && ((reqLen == 5'h00) || (reqLen > exio_pkg::LEN_MAX))
      |=> respError && (respData == exio_pkg::RESP_RESET);
  endproperty
  a_lenRange: assert property (p_lenRange) else $error("bad count not refused");

  property p_inputLive;
    @(posedge clock) disable iff (!arst_n)
      okNow && !reqWrite && !reqOutput |=> !respError && (respData[0] == inSeen[idxSeen]);
  endproperty
  a_inputLive: assert property (p_inputLive) else $error("input read not live");

  property p_singleBit;
    @(posedge clock) disable iff (!arst_n)
      okNow && !reqWrite && !reqGroup |=> respData[23:1] == 23'h000000;
  endproperty
  a_singleBit: assert property (p_singleBit) else $error("single read wider than a bit");

  property p_groupWeight;
    @(posedge clock) disable iff (!arst_n)
      okNow && !reqWrite && !reqOutput && reqGroup
      |=> ((respData >> lenSeen) == 24'h000000)
          && (respData[lenSeen - 5'h01] == inSeen[idxSeen + {3'h0, lenSeen} - 8'h01]);
  endproperty
  a_groupWeight: assert property (p_groupWeight) else $error("group input weighting wrong");

  property p_singleWrite;
    @(posedge clock) disable iff (!arst_n)
      okNow && reqWrite && !reqGroup |=> outPins[idxSeen] == (dataSeen != '0);
  endproperty
  a_singleWrite: assert property (p_singleWrite) else $error("single output value wrong");

  property p_singleRead;
    @(posedge clock) disable iff (!arst_n)
      okNow && !reqWrite && reqOutput && !reqGroup
      |=> (respData[0] == cmdSeen[idxSeen]) && (outPins == cmdSeen);
  endproperty
  a_singleRead: assert property (p_singleRead) else $error("output readback wrong");

  property p_groupWrite;
    @(posedge clock) disable iff (!arst_n)
      okNow && reqWrite && reqGroup
      |=> (outPins[idxSeen] == dataSeen[0])
          && (outPins[idxSeen + {3'h0, lenSeen} - 8'h01] == dataSeen[lenSeen - 5'h01]);
  endproperty
  a_groupWrite: assert property (p_groupWrite) else $error("group output bits wrong");

  property p_groupRead;
    @(posedge clock) disable iff (!arst_n)
      okNow && !reqWrite && reqOutput && reqGroup
      |=> (respData[0] == cmdSeen[idxSeen]) && ((respData >> lenSeen) == 24'h000000);
  endproperty
  a_groupRead: assert property (p_groupRead) else $error("group readback wrong");

  property p_keepOthers;
    @(posedge clock) disable iff (!arst_n)
      okNow && reqWrite && (dec.flatIdx != 8'h00)
      |=> outPins[idxSeen - 8'h01] == cmdSeen[idxSeen - 8'h01];
  endproperty
  a_keepOthers: assert property (p_keepOthers) else $error("output below run changed");

  property p_refuseHold;
    @(posedge clock) disable iff (!arst_n)
      reqValid && !dec.runOk |=> respError && (outPins == cmdSeen);
  endproperty
  a_refuseHold: assert property (p_refuseHold) else $error("bad run not refused");

  property p_inputNoCmd;
    @(posedge clock) disable iff (!arst_n)
      okNow && !reqWrite && !reqOutput |=> outPins == cmdSeen;
  endproperty
  a_inputNoCmd: assert property (p_inputNoCmd) else $error("input read moved outputs");

  property p_writeQuiet;
    @(posedge clock) disable iff (!arst_n)
      okNow && reqWrite |=> !respError && (respData == exio_pkg::RESP_RESET);
  endproperty
  a_writeQuiet: assert property (p_writeQuiet) else $error("write answer not clean");

  property p_readKeeps;
    @(posedge clock) disable iff (!arst_n)
      okNow && !reqWrite && reqOutput |=> outPins == cmdSeen;
  endproperty
  a_readKeeps: assert property (p_readKeeps) else $error("output read moved outputs");

  property p_groupReadTop;
    @(posedge clock) disable iff (!arst_n)
      okNow && !reqWrite && reqOutput && reqGroup
      |=> respData[lenSeen - 5'h01] == cmdSeen[idxSeen + {3'h0, lenSeen} - 8'h01];
  endproperty
  a_groupReadTop: assert property (p_groupReadTop) else $error("group readback top wrong");

  property p_keepAbove;
    @(posedge clock) disable iff (!arst_n)
      okNow && reqWrite && ((dec.flatIdx + {3'h0, effLen}) < 8'(exio_pkg::TOTAL))
      |=> outPins[idxSeen + {3'h0, lenSeen}] == cmdSeen[idxSeen + {3'h0, lenSeen}];
  endproperty
  a_keepAbove: assert property (p_keepAbove) else $error("output above run changed");
endmodule
`default_nettype wire

// ### exio_pkg.sv
`default_nettype none
package exio_pkg;
  localparam int          BOARDS      = 4;
  localparam int          POINTS      = 48;
  localparam int          TOTAL       = BOARDS * POINTS;
  localparam int          MAX_LEN     = 24;
  localparam int          DATA_W      = 32;
  localparam logic [3:0]  BOARD_FIRST = 4'h1;
  localparam logic [3:0]  BOARD_LAST  = 4'h4;
  localparam logic [3:0]  TENS_LAST   = 4'h4;
  localparam logic [3:0]  ONES_LAST   = 4'h9;
  localparam logic [7:0]  POINTS_B    = 8'h30;
  localparam logic [4:0]  LEN_MIN     = 5'h01;
  localparam logic [4:0]  LEN_MAX     = 5'h18;
  localparam logic [23:0] RESP_RESET  = 24'h000000;
endpackage
`default_nettype wire

// ### exio_dec_if.sv
`timescale 1ns/1ns
`default_nettype none
interface exio_dec_if;
  logic [11:0] pointBcd;
  logic [4:0]  runLen;
  logic [7:0]  flatIdx;
  logic        pointOk;
  logic        runOk;
  modport dec  (input pointBcd, input runLen, output flatIdx, output pointOk, output runOk);
  modport user (output pointBcd, output runLen, input flatIdx, input pointOk, input runOk);
endinterface
`default_nettype wire

// ### exio_point_decode.sv
`timescale 1ns/1ns
`default_nettype none
module exio_point_decode (
  // decode request and result
  exio_dec_if.dec d
);
  logic [3:0] hund;
  logic [3:0] tens;
  logic [3:0] ones;
  logic [7:0] local8;
  logic [7:0] board8;

  always_comb begin
    hund   = d.pointBcd[11:8];
    tens   = d.pointBcd[7:4];
    ones   = d.pointBcd[3:0];
    // board and point digits are checked separately, so 148..199 are refused
    d.pointOk = (hund >= exio_pkg::BOARD_FIRST) && (hund <= exio_pkg::BOARD_LAST)
              && (tens <= exio_pkg::TENS_LAST) && (ones <= exio_pkg::ONES_LAST)
              && !((tens == exio_pkg::TENS_LAST) && (ones > 4'h7));
    local8 = 8'({4'h0, tens} * 8'h0A) + {4'h0, ones};
    board8 = {4'h0, hund - exio_pkg::BOARD_FIRST};
    d.flatIdx = 8'(board8 * exio_pkg::POINTS_B) + local8;
    // a run may not spill onto the next board
    d.runOk = (d.runLen >= exio_pkg::LEN_MIN) && (d.runLen <= exio_pkg::LEN_MAX)
            && ((local8 + {3'h0, d.runLen}) <= exio_pkg::POINTS_B);
  end
endmodule
`default_nettype wire

// ### exio_field.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// field switches and sensors
// ------------------------------------------------------------
module exio_field (
  // clock
  input  wire logic                       clock,
  // switch states set by the bench
  input  wire logic [exio_pkg::TOTAL-1:0] switches,
  // sensed levels toward the block
  output logic      [exio_pkg::TOTAL-1:0] inPins
);
  // sensors land one edge after a switch moves, so pins never change mid-cycle
  always_ff @(posedge clock) begin
    inPins <= switches;
  end
endmodule
`default_nettype wire

// ### expansion_io_group_access_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module expansion_io_group_access_tb_top;
  logic         clock, arst_n, reqValid, reqWrite, reqOutput, reqGroup;
  logic [11:0]  reqPoint;
  logic [4:0]   reqLen;
  logic [31:0]  reqData;
  logic         respValid, respError;
  logic [23:0]  respData;
  logic [191:0] inPins, outPins, switches, expOut;
  int           errors, compares, cycles;

  exio_access uut (.clock(clock), .arst_n(arst_n), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqOutput(reqOutput), .reqGroup(reqGroup), .reqPoint(reqPoint), .reqLen(reqLen),
    .reqData(reqData), .respValid(respValid), .respError(respError), .respData(respData),
    .inPins(inPins), .outPins(outPins));
  exio_field field (.clock(clock), .switches(switches), .inPins(inPins));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [191:0] seen, input logic [191:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // one request, answer judged the cycle after it is taken
  task automatic acc(input logic w, o, g, input logic [11:0] pt, input logic [4:0] len,
                     input logic [31:0] d, input logic err, input logic [23:0] exp);
    @(posedge clock);
    #1;
    {reqWrite, reqOutput, reqGroup, reqPoint, reqLen, reqData} = {w, o, g, pt, len, d};
    reqValid = 1'b1;
    @(posedge clock);
    #1;
    reqValid = 1'b0;
    check(192'(respValid), 192'h1);
    check(192'(respError), 192'(err));
    check(192'(respData), 192'(exp));
    check(outPins, expOut);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_write();
    expOut[57:55] = 3'h6;
    acc(1'b1, 1'b1, 1'b1, 12'h207, 5'h03, 32'h6, 1'b0, 24'h0);
    expOut[167:144] = 24'hABCDEF;
    acc(1'b1, 1'b1, 1'b1, 12'h400, 5'h18, 32'hFFABCDEF, 1'b0, 24'h0);
    acc(1'b0, 1'b1, 1'b1, 12'h208, 5'h02, 32'h0, 1'b0, 24'h3);
  endtask
  task automatic t_single();
    expOut[6] = 1'b1;
    acc(1'b1, 1'b1, 1'b0, 12'h106, 5'h00, 32'hFFFFFFFD, 1'b0, 24'h0);
    acc(1'b0, 1'b1, 1'b0, 12'h106, 5'h18, 32'h0, 1'b0, 24'h1);
    expOut[6] = 1'b0;
    acc(1'b1, 1'b1, 1'b0, 12'h106, 5'h00, 32'h0, 1'b0, 24'h0);
    acc(1'b0, 1'b1, 1'b0, 12'h417, 5'h00, 32'h0, 1'b0, 24'h1);
  endtask
  task automatic t_input();
    switches[191] = 1'b1;
    switches[120:97] = 24'h5A3C81;
    acc(1'b0, 1'b0, 1'b0, 12'h447, 5'h00, 32'h0, 1'b0, 24'h1);
    acc(1'b0, 1'b0, 1'b1, 12'h301, 5'h18, 32'h0, 1'b0, 24'h5A3C81);
    switches = '0;
    acc(1'b0, 1'b0, 1'b0, 12'h447, 5'h00, 32'h0, 1'b0, 24'h0);
  endtask
  task automatic t_refuse();
    logic [11:0] pts [8] = '{12'h148, 12'h047, 12'h500, 12'h1A0, 12'h10A, 12'h140,
                             12'h100, 12'h100};
    logic [4:0]  lens [8] = '{5'h01, 5'h01, 5'h01, 5'h01, 5'h01, 5'h09, 5'h00, 5'h19};
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, 1'b1, 1'b1, pts[i], lens[i], 32'hFFFFFF, 1'b1, 24'h0);
    end
    acc(1'b1, 1'b0, 1'b0, 12'h100, 5'h00, 32'h1, 1'b1, 24'h0);
    acc(1'b0, 1'b1, 1'b1, 12'h124, 5'h18, 32'h0, 1'b0, 24'h0);
  endtask
  // ------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    {reqValid, reqWrite, reqOutput, reqGroup, reqPoint, reqLen, reqData} = '0;
    {switches, expOut} = '0;
    arst_n = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    arst_n = 1'b1;
    check(outPins, expOut);
    t_write();
    t_single();
    t_input();
    t_refuse();
    test_done();
  end
endmodule
`default_nettype wire
